// >>> rtl/boot_config_latches.sv
// Purpose: nonvolatile boot configuration latches with AXI4-Lite access
// Assumes: array content persists across rst_n; power-up value is a parameter
// Notes: configuration outputs other than port_reset_drive_mode_high reflect the array as sampled at reset release;
//   writes land in the array at once but reach the outputs only after the next rst_n;
//   0x10 reads the pending-change flag and 0x14 the rewrite count since reset
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ns
module boot_config_latches
  import boot_config_pkg::*;
#(
  parameter logic ext_reset_default = 1'b0,
  parameter logic [7:0] phase_delay_default = 8'h00
)
(
  input wire logic clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration levels, constant between resets
  output logic [15:0] port_reset_drive_mode_low,
  output logic [15:0] port_reset_drive_mode_high,
  output logic [1:0] port15_reset_drive_mode,
  output logic ext_reset_pin_select,
  output logic debug_access_enable,
  output logic boot_clock_speed_select,
  output logic [1:0] debug_port_select,
  output logic ecc_region_use,
  output logic [3:0] digital_clock_phase_delay
);

  // four-byte array; power-up content stands in for the erased-then-defaulted array
  logic [7:0] config_latch [num_bytes];
  logic array_loaded = 1'b0;
  logic [7:0] sampled [num_bytes];
  logic pending_change;
  logic [15:0] write_count;
  logic [31:0] read_value;

  // Write channels are parked here until both halves have arrived
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic array_write;

  function automatic logic is_array(input logic [7:0] addr);
    is_array = (addr[7:4] == 4'h0) && (addr[1:0] == 2'b00);
  endfunction : is_array

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = is_array(addr) || (addr == addr_status) || (addr == addr_write_count);
  endfunction : is_mapped

  // Word index of an array address; bits 1:0 are zero for a mapped word
  function automatic logic [1:0] byte_index(input logic [7:0] addr);
    byte_index = addr[3:2];
  endfunction : byte_index

  function automatic logic [7:0] default_byte(input int unsigned i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      0: v = reset_port_modes_low;
      1: v = reset_port_modes_high;
      2:
      begin
        v = reset_reset_pin_debug;
        v[pos_ext_reset] = ext_reset_default;
      end
      default:
      begin
        v = reset_boot_clock_debug;
        v[pos_phase_delay +: 4] = phase_delay_default[3:0];
      end
    endcase
    default_byte = v;
  endfunction : default_byte

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  // Only the low byte lane reaches the array; the upper lanes are ignored
  assign array_write = do_write && is_array(aw_addr) && w_strb[0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
    begin
      aw_held <= 1'b0;
    end
  end

  // Data may arrive before or after its address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
    begin
      w_held <= 1'b0;
    end
  end

  // Response stands until taken; new writes stall meanwhile
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Writes to the status words are accepted and have no effect
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_bresp <= resp_okay;
    end
    else if (do_write)
    begin
      s_axi_bresp <= is_mapped(aw_addr) ? resp_okay : resp_slverr;
    end
  end

  // Nonvolatile: no async reset, so content survives rst_n; filled once after power-up
  always_ff @(posedge clk)
  begin
    if (!array_loaded)
    begin
      for (int i = 0; i < num_bytes; i++)
      begin
        config_latch[i] <= default_byte(i);
      end
    end
    else if (array_write)
    begin
      config_latch[byte_index(aw_addr)] <= w_data[7:0];
    end
  end

  // Tracks power-up fill only; a later rst_n must not reload defaults
  always_ff @(posedge clk)
  begin
    array_loaded <= 1'b1;
  end

  // wear counter lets software see how often the array was rewritten
  // It saturates rather than wraps, so heavy rewriting never looks light
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_count <= 16'h0000;
    end
    else if (array_write && (write_count != 16'hFFFF))
    begin
      write_count <= write_count + 16'h0001;
    end
  end

  // set by any array write, hold until next reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending_change <= 1'b0;
    end
    else if (array_write)
    begin
      pending_change <= 1'b1;
    end
  end

  // High through reset and for the one edge after it; that edge captures the array
  logic sample_armed;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sample_armed <= 1'b1;
    end
    else
    begin
      sample_armed <= 1'b0;
    end
  end

  // the edge after reset release captures these; power-up fill may still be pending
  generate
    for (genvar b = 0; b < num_bytes; b++)
    begin : g_sample
      assign sampled[b] = array_loaded ? config_latch[b] : default_byte(b);
    end
  endgenerate

  // one field per port; port logic fans it out to all eight pins
  // fields keep drive_mode_type coding; reset leaves every port analog hi-z
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_reset_drive_mode_low <= 16'h0000;
    end
    else if (sample_armed)
    begin
      port_reset_drive_mode_low <= {sampled[idx_port_modes_high], sampled[idx_port_modes_low]};
    end
  end

  // Reserved: no port uses the upper word
  assign port_reset_drive_mode_high = 16'h0000;

  // shared pin role, debug gate; port 15 mode sits in the low bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port15_reset_drive_mode <= 2'h0;
      ext_reset_pin_select <= 1'b0;
      debug_access_enable <= 1'b0;
    end
    else if (sample_armed)
    begin
      port15_reset_drive_mode <= sampled[idx_reset_pin_debug][1:0];
      ext_reset_pin_select <= sampled[idx_reset_pin_debug][pos_ext_reset];
      debug_access_enable <= sampled[idx_reset_pin_debug][pos_debug_enable];
    end
  end

  // spare flash use, digital clock phase delay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_clock_speed_select <= 1'b0;
      debug_port_select <= 2'h0;
      ecc_region_use <= 1'b0;
      digital_clock_phase_delay <= 4'h0;
    end
    else if (sample_armed)
    begin
      boot_clock_speed_select <= sampled[idx_boot_clock_debug][pos_boot_speed];
      debug_port_select <= sampled[idx_boot_clock_debug][pos_debug_port +: 2];
      ecc_region_use <= sampled[idx_boot_clock_debug][pos_ecc_use];
      digital_clock_phase_delay <= sampled[idx_boot_clock_debug][pos_phase_delay +: 4];
    end
  end

  // Reads never stall behind a write; one read is answered at a time
  assign s_axi_arready = !s_axi_rvalid;

  // Unmapped addresses read as zero
  always_comb
  begin
    read_value = 32'h0000_0000;
    if (is_array(s_axi_araddr))
    begin
      read_value = {24'h00_0000, config_latch[byte_index(s_axi_araddr)]};
    end
    else if (s_axi_araddr == addr_status)
    begin
      read_value = {31'h0000_0000, pending_change};
    end
    else if (s_axi_araddr == addr_write_count)
    begin
      read_value = {16'h0000, write_count};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Data and response are latched with the address and stand until taken
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rdata <= read_value;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
    end
  end

endmodule : boot_config_latches

// >>> rtl/boot_config_pkg.sv
// Purpose: constants for the boot configuration latch block
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: byte addresses are four times the register index
package boot_config_pkg;
  localparam int unsigned num_bytes = 4;
  localparam logic [1:0] idx_port_modes_low = 2'h0;
  localparam logic [1:0] idx_port_modes_high = 2'h1;
  localparam logic [1:0] idx_reset_pin_debug = 2'h2;
  localparam logic [1:0] idx_boot_clock_debug = 2'h3;
  localparam logic [7:0] addr_status = 8'h10;
  localparam logic [7:0] addr_write_count = 8'h14;
  localparam int unsigned pos_ext_reset = 7;
  localparam int unsigned pos_debug_enable = 6;
  localparam int unsigned pos_boot_speed = 0;
  localparam int unsigned pos_debug_port = 1;
  localparam int unsigned pos_ecc_use = 3;
  localparam int unsigned pos_phase_delay = 4;
  localparam logic [7:0] reset_port_modes_low = 8'h00;
  localparam logic [7:0] reset_port_modes_high = 8'h00;
  localparam logic [7:0] reset_reset_pin_debug = 8'h40;
  localparam logic [7:0] reset_boot_clock_debug = 8'h02;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum logic [1:0]
  {
    drive_hiz_analog = 2'h0,
    drive_hiz_digital = 2'h1,
    drive_pull_up = 2'h2,
    drive_pull_down = 2'h3
  } drive_mode_type;
  typedef enum logic [1:0]
  {
    dbg_jtag5 = 2'h0,
    dbg_jtag4 = 2'h1,
    dbg_swd = 2'h2,
    dbg_none = 2'h3
  } debug_port_type;
endpackage : boot_config_pkg

// >>> sim/boot_config_latches_chk.sv
// Purpose: port checks for boot_config_latches
// Assumes: one clock, rst_n async active low
// Notes: array bytes are not visible at the ports
`timescale 1ns/1ns
module boot_config_latches_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [15:0] port_reset_drive_mode_low,
  input wire logic [15:0] port_reset_drive_mode_high,
  input wire logic [3:0] digital_clock_phase_delay
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Outputs settle one cycle after the sampling edge, so wait three
  AST_CFG_HOLD: assert property ($past(rst_n, 3) |-> $stable({port_reset_drive_mode_low, digital_clock_phase_delay}))
    else $error("config moved");
  AST_HIGH_ZERO: assert property (port_reset_drive_mode_high == 16'h0000)
    else $error("reserved modes set");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("no write answer");
  AST_AW_STALL: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken early");
  AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data moved");
  AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($fell(s_axi_rvalid));
endmodule : boot_config_latches_chk

bind boot_config_latches boot_config_latches_chk boot_config_latches_chk_i (.*);

// >>> sim/boot_config_latches_test.sv
// Purpose: self-checking bench for boot_config_latches
// Assumes: default parameters, 25 MHz clock
// Notes: outputs follow rewritten bytes only after a reset
`timescale 1ns/1ns
module boot_config_latches_test;
  import boot_config_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_rready = 1'b0, ext_reset_pin_select, debug_access_enable;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, boot_clock_speed_select;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata, seed = 32'h000135EC, rd, prev;
  logic [3:0] s_axi_wstrb = 4'hF, digital_clock_phase_delay;
  logic [1:0] s_axi_bresp, s_axi_rresp, port15_reset_drive_mode, debug_port_select, rs;
  logic [15:0] port_reset_drive_mode_low, port_reset_drive_mode_high;
  logic ecc_region_use;
  logic [7:0] b [4];
  int num_errors = 0, tests_run = 0;
  wire [31:0] outs = {4'h0, port_reset_drive_mode_low, port15_reset_drive_mode, ext_reset_pin_select,
    debug_access_enable, boot_clock_speed_select, debug_port_select, ecc_region_use, digital_clock_phase_delay};

  always #20 clk = ~clk;

  boot_config_latches boot_config_latches_i (.*);

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [31:0] cfg();
    return {4'h0, b[1], b[0], b[2][1:0], b[2][7:6], b[3][0], b[3][2:1], b[3][3], b[3][7:4]};
  endfunction : cfg

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // Ready is offered with the request and held until the answer is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (!(w ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1));
    rd = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    b = '{8'h00, 8'h00, 8'h40, 8'h02};
    chk(outs, cfg());
    // Five rounds only, to spare latch endurance
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b0, addr_status, 8'h00);
      chk(rd, 32'h00000000);
      bus(1'b0, addr_write_count, 8'h00);
      chk(rd, 32'h00000000);
      for (int i = 0; i < 4; i++)
      begin
        bus(1'b0, 8'(i * 4), 8'h00);
        chk(rd, {24'h000000, b[i]});
      end
      if (k < 4)
      begin
        prev = cfg();
        for (int i = 0; i < 4; i++)
        begin
          rd = xs();
          b[i] = rd[7:0];
        end
        if (k == 0) b[0] = 8'hE4;
        b[3][2:1] = 2'(k);
        for (int i = 0; i < 4; i++)
        begin
          bus(1'b1, 8'(i * 4), b[i]);
          chk({30'h0, rs}, {30'h0, resp_okay});
        end
        bus(1'b0, addr_status, 8'h00);
        chk(rd, 32'h00000001);
        bus(1'b0, addr_write_count, 8'h00);
        chk(rd, 32'h00000004);
        chk(outs, prev);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(outs, cfg());
      end
      $display("Round %0d done", k);
    end
    bus(1'b0, 8'h20, 8'h00);
    chk(rd, 32'h00000000);
    chk({30'h0, rs}, {30'h0, resp_slverr});
    bus(1'b1, 8'h24, 8'hFF);
    chk({30'h0, rs}, {30'h0, resp_slverr});
    give_verdict();
  end

  // About 220 cycles are needed; over thirteen times that means a hang
  initial
  begin
    repeat (3000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule : boot_config_latches_test
